// [rbcp_top.v]
// Purpose: Receive channel power, reclocker path and self-test output for two channels
// Assumes: Received characters arrive on ref_clk with a valid pulse; lock pins are asynchronous
// Notes: Latch banks are writable and readable over the plain register port

`include "rbcp_defines.vh"

module rbcp_top #(
  parameter SETTLE_CYCLES = (`RBCP_SETTLE_NS + `RBCP_CLK_NS - 1) / `RBCP_CLK_NS
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [3:0] cfg_addr,
  input wire [7:0] cfg_wdata,
  input wire config_write_strobe_n,
  input wire cfg_rd,
  output reg [7:0] cfg_rdata,
  input wire [19:0] rx_char_in,
  input wire [1:0] rx_char_valid,
  input wire [1:0] rx_pll_lock,
  output wire [19:0] rx_parallel_char,
  output wire [1:0] rx_parallel_valid,
  output wire [1:0] selftest_status_bit,
  output wire [1:0] link_fault_indicator_n,
  output wire [19:0] reclock_char,
  output wire [1:0] reclock_char_valid,
  output wire [1:0] reclock_driver_one_enable,
  output wire [1:0] reclock_driver_two_enable,
  output wire [1:0] reclock_logic_power,
  output wire [1:0] reclock_settling,
  output wire [1:0] rx_channel_power_latch,
  output wire [1:0] tx_driver_one_enable,
  output wire [1:0] tx_driver_two_enable,
  output wire [1:0] tx_logic_power
);

  // ****************************************
  // Local constants
  // ****************************************
  localparam [12:0] SETTLE_LOAD = SETTLE_CYCLES[12:0];
  localparam [12:0] SETTLE_ZERO = 13'h0000;

  // ****************************************
  // Shared write decode
  // ****************************************
  wire wr_en;
  wire [13:0] latch_flat;
  wire [15:0] status_flat;
  reg [7:0] rdata_d;

  assign wr_en = ~config_write_strobe_n;

  // ****************************************
  // Per-channel logic
  // ****************************************
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      reg [6:0] latch_q;
      reg pwr_q;
      reg reclk_pwr_q;
      reg tx_pwr_q;
      reg lfi_n_q;
      reg [12:0] settle_q;
      reg [9:0] char_d1_q;
      reg valid_d1_q;
      reg [9:0] par_q;
      reg par_valid_q;
      reg st_bit_q;
      reg [9:0] reclk_q;
      reg reclk_valid_q;
      reg settling_q;
      reg [7:0] status_q;
      wire lock_s;
      wire rx_take;
      wire rclk_on;
      wire tx_on;
      wire check_en;
      wire [2:0] code;
      wire [1:0] chk_state;
      wire [9:0] char_in;
      wire [3:0] bank;

      assign char_in = rx_char_in[ch*10 +: 10];
      assign bank = (ch == 0) ? `RBCP_BANK_CHA : `RBCP_BANK_CHB;
      assign check_en = pwr_q && (latch_q[`RBCP_F_MODE_HI:`RBCP_F_MODE_LO] == `RBCP_MODE_CHECK);
      assign rx_take = rx_char_valid[ch] & pwr_q;
      assign rclk_on = latch_q[`RBCP_F_RDRV1] | latch_q[`RBCP_F_RDRV2];
      assign tx_on = latch_q[`RBCP_F_TDRV1] | latch_q[`RBCP_F_TDRV2];

      rbcp_sync u_lock_sync (
        .clk(ref_clk),
        .rst_n(rst_n),
        .d(rx_pll_lock[ch]),
        .q(lock_s)
      );

      // ****************************************
      // Configuration latch bank
      // ****************************************
      // Reset value clears drivers, power and self-test mode
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          latch_q <= `RBCP_LATCH_RST;
        end else if (wr_en && cfg_addr == bank) begin
          latch_q <= cfg_wdata[6:0];
        end
      end

      // ****************************************
      // Power controls
      // ****************************************
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          pwr_q <= 1'b0;
          lfi_n_q <= 1'b0;
        end else begin
          pwr_q <= latch_q[`RBCP_F_RXPWR];
          // Fault is low; a powered-down channel holds it low
          lfi_n_q <= latch_q[`RBCP_F_RXPWR] & lock_s;
        end
      end

      // Driver logic powers down only when both of its drivers are off
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          reclk_pwr_q <= 1'b0;
          tx_pwr_q <= 1'b0;
        end else begin
          reclk_pwr_q <= rclk_on;
          tx_pwr_q <= tx_on;
        end
      end

      // Settle flag after reclocker wakes from full power-down, a hint for software
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          settle_q <= SETTLE_ZERO;
          settling_q <= 1'b0;
        end else if (!reclk_pwr_q && rclk_on) begin
          settle_q <= SETTLE_LOAD;
          settling_q <= 1'b1;
        end else if (settle_q != SETTLE_ZERO) begin
          settle_q <= settle_q - 13'h0001;
          settling_q <= (settle_q != 13'h0001);
        end else begin
          settling_q <= 1'b0;
        end
      end

      // ****************************************
      // Pattern checker
      // ****************************************
      rbcp_checker u_chk (
        .clk(ref_clk),
        .rst_n(rst_n),
        .check_en(check_en),
        .locked(lock_s),
        .char_valid(rx_char_valid[ch] & pwr_q),
        .char_in(char_in),
        .status_code(code),
        .state(chk_state)
      );

      // ****************************************
      // Parallel output
      // ****************************************
      // One stage of delay lets the checker code line up with its character
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          char_d1_q <= 10'h000;
          valid_d1_q <= 1'b0;
          par_q <= 10'h000;
          par_valid_q <= 1'b0;
        end else begin
          char_d1_q <= char_in;
          valid_d1_q <= rx_take;
          par_valid_q <= valid_d1_q;
          if (valid_d1_q) begin
            if (check_en) begin
              // Low bits carry {data bit 1, data bit 0} = {code[0], code[1]}
              par_q <= {char_d1_q[9:2], code[0], code[1]};
            end else begin
              par_q <= char_d1_q;
            end
          end
        end
      end

      // Status bit drops as soon as checking ends, not at the next character
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          st_bit_q <= 1'b0;
        end else if (!check_en) begin
          st_bit_q <= 1'b0;
        end else if (valid_d1_q) begin
          st_bit_q <= code[2];
        end
      end

      // ****************************************
      // Reclocker path
      // ****************************************
      // Reclocker runs only while one of its drivers is on
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          reclk_q <= 10'h000;
          reclk_valid_q <= 1'b0;
        end else begin
          reclk_valid_q <= rx_take & reclk_pwr_q;
          if (rx_take && reclk_pwr_q) begin
            reclk_q <= char_in;
          end
        end
      end

      // ****************************************
      // Status snapshot
      // ****************************************
      // A registered copy keeps the read path short; reads lag one cycle
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          status_q <= 8'h00;
        end else begin
          status_q <= {code, chk_state, settling_q, ~lfi_n_q, lock_s};
        end
      end

      assign latch_flat[ch*7 +: 7] = latch_q;
      assign status_flat[ch*8 +: 8] = status_q;
      assign rx_parallel_char[ch*10 +: 10] = par_q;
      assign rx_parallel_valid[ch] = par_valid_q;
      assign selftest_status_bit[ch] = st_bit_q;
      assign link_fault_indicator_n[ch] = lfi_n_q;
      assign reclock_char[ch*10 +: 10] = reclk_q;
      assign reclock_char_valid[ch] = reclk_valid_q;
      assign reclock_driver_one_enable[ch] = latch_q[`RBCP_F_RDRV1];
      assign reclock_driver_two_enable[ch] = latch_q[`RBCP_F_RDRV2];
      assign reclock_logic_power[ch] = reclk_pwr_q;
      assign rx_channel_power_latch[ch] = pwr_q;
      assign tx_driver_one_enable[ch] = latch_q[`RBCP_F_TDRV1];
      assign tx_driver_two_enable[ch] = latch_q[`RBCP_F_TDRV2];
      assign tx_logic_power[ch] = tx_pwr_q;
      assign reclock_settling[ch] = settling_q;
    end
  endgenerate

  // ****************************************
  // Register read port
  // ****************************************
  // Unmapped banks read as zero so software can probe the map safely
  always @* begin
    case (cfg_addr)
      `RBCP_BANK_CHA: rdata_d = {1'b0, latch_flat[6:0]};
      `RBCP_BANK_CHB: rdata_d = {1'b0, latch_flat[13:7]};
      `RBCP_STAT_CHA: rdata_d = status_flat[7:0];
      `RBCP_STAT_CHB: rdata_d = status_flat[15:8];
      default: rdata_d = 8'h00;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_rd) begin
      cfg_rdata <= rdata_d;
    end else begin
      cfg_rdata <= 8'h00;
    end
  end

endmodule // rbcp_top

// [rbcp_defines.vh]
// Purpose: Shared constants of the receive self-test and channel power block
// Assumes: One 20 MHz clock, two receive channels
// Notes: Bank offsets and latch bit positions are used only by rbcp_top; status bit positions by no module; checker constants by rbcp_checker
`ifndef RBCP_DEFINES_VH
`define RBCP_DEFINES_VH

// ****************************************
// Register offsets (4-bit bank address)
// ****************************************
`define RBCP_BANK_CHA 4'h0
`define RBCP_BANK_CHB 4'h1
`define RBCP_STAT_CHA 4'h2
`define RBCP_STAT_CHB 4'h3

// ****************************************
// Latch bank fields
// ****************************************
`define RBCP_F_RXPWR 0
`define RBCP_F_RDRV1 1
`define RBCP_F_RDRV2 2
`define RBCP_F_TDRV1 3
`define RBCP_F_TDRV2 4
`define RBCP_F_MODE_LO 5
`define RBCP_F_MODE_HI 6
`define RBCP_LATCH_RST 7'h00
`define RBCP_MODE_CHECK 2'h2

// ****************************************
// Status register fields
// ****************************************
`define RBCP_S_LOCK 0
`define RBCP_S_FAULT 1
`define RBCP_S_SETTLE 2
`define RBCP_S_STATE_LO 3
`define RBCP_S_STATE_HI 4
`define RBCP_S_CODE_LO 5
`define RBCP_S_CODE_HI 7

// ****************************************
// Checker constants
// ****************************************
`define RBCP_LFSR_SEED 9'h1FF
`define RBCP_LOOP_LAST 9'h1FE
`define RBCP_ABORT_LIMIT 5'h10
`define RBCP_ST_START 2'h0
`define RBCP_ST_WAIT 2'h1
`define RBCP_ST_CMP 2'h2

// Status codes, bit order {status bit, data bit 0, data bit 1}
`define RBCP_CODE_MATCH 3'h0
`define RBCP_CODE_ERR 3'h1
`define RBCP_CODE_LOOP_ERR 3'h2
`define RBCP_CODE_LOOP_OK 3'h4
`define RBCP_CODE_WAIT 3'h6

// ****************************************
// Timing
// ****************************************
`define RBCP_CLK_NS 50
`define RBCP_SETTLE_NS 250000

`endif

// [rbcp_sync.v]
// Purpose: Two-stage synchroniser for a level from outside the clock domain
// Assumes: Input is a slow level
// Notes: First stage feeds only the second stage
module rbcp_sync (
  input wire clk,
  input wire rst_n,
  input wire d,
  output wire q
);
  reg meta_q;
  reg sync_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule // rbcp_sync

// [rbcp_checker.v]
// Purpose: Receive pattern checker with 9-bit LFSR and abort/resync control
// Assumes: char_valid marks one deserialised character per pulse
// Notes: status_code updates on the cycle after each valid character
`include "rbcp_defines.vh"
module rbcp_checker (
  input wire clk,
  input wire rst_n,
  input wire check_en,
  input wire locked,
  input wire char_valid,
  input wire [9:0] char_in,
  output reg [2:0] status_code,
  output reg [1:0] state
);
  reg [8:0] lfsr_q;
  reg [8:0] pos_q;
  reg [4:0] diff_q;
  reg loop_err_q;
  wire [8:0] lfsr_nxt;
  wire [9:0] expect_char;
  wire match;
  wire last;

  // x^9 + x^5 + 1 gives the full 511-state cycle
  assign lfsr_nxt = {lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]};
  assign expect_char = {lfsr_q, ^lfsr_q};
  assign match = (char_in == expect_char);
  assign last = (pos_q == `RBCP_LOOP_LAST);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= `RBCP_ST_START;
      lfsr_q <= `RBCP_LFSR_SEED;
      pos_q <= 9'h000;
      diff_q <= 5'h00;
      loop_err_q <= 1'b0;
      status_code <= `RBCP_CODE_WAIT;
    end else if (!check_en || !locked) begin
      // Loss of lock overrides every state
      state <= `RBCP_ST_START;
      lfsr_q <= `RBCP_LFSR_SEED;
      status_code <= `RBCP_CODE_WAIT;
    end else begin
      case (state)
        `RBCP_ST_START: begin
          state <= `RBCP_ST_WAIT;
          lfsr_q <= `RBCP_LFSR_SEED;
          pos_q <= 9'h000;
          diff_q <= 5'h00;
          loop_err_q <= 1'b0;
          status_code <= `RBCP_CODE_WAIT;
        end
        `RBCP_ST_WAIT: begin
          if (char_valid) begin
            if (match) begin
              // Sync on the first sequence character
              state <= `RBCP_ST_CMP;
              lfsr_q <= lfsr_nxt;
              pos_q <= 9'h001;
              diff_q <= 5'h00;
              loop_err_q <= 1'b0;
              status_code <= `RBCP_CODE_MATCH;
            end else begin
              status_code <= `RBCP_CODE_WAIT;
            end
          end
        end
        `RBCP_ST_CMP: begin
          if (char_valid) begin
            if (!match && diff_q == `RBCP_ABORT_LIMIT) begin
              state <= `RBCP_ST_WAIT;
              lfsr_q <= `RBCP_LFSR_SEED;
              pos_q <= 9'h000;
              diff_q <= 5'h00;
              status_code <= `RBCP_CODE_ERR;
            end else begin
              lfsr_q <= lfsr_nxt;
              pos_q <= last ? 9'h000 : pos_q + 9'h001;
              if (!match)
                diff_q <= diff_q + 5'h01;
              else if (diff_q != 5'h00)
                diff_q <= diff_q - 5'h01;
              // Loop code stands for every character of the loop, this one included
              if (last)
                status_code <= (loop_err_q || !match) ? `RBCP_CODE_LOOP_ERR : `RBCP_CODE_LOOP_OK;
              else
                status_code <= match ? `RBCP_CODE_MATCH : `RBCP_CODE_ERR;
              loop_err_q <= last ? 1'b0 : (loop_err_q | ~match);
            end
          end
        end
        default: begin
          state <= `RBCP_ST_START;
        end
      endcase
    end
  end
endmodule // rbcp_checker

// [rbcp_chk.sv]
// Purpose: Port assertions for the receive self-test and power block
// Assumes: Channel A is watched; channel B shares the same logic
// Notes: Latch outputs are taken to follow a write by two edges
module rbcp_chk (
  input logic ref_clk,
  input logic rst_n,
  input logic [3:0] cfg_addr,
  input logic [7:0] cfg_wdata,
  input logic config_write_strobe_n,
  input logic [19:0] rx_char_in,
  input logic [1:0] rx_char_valid,
  input logic [19:0] rx_parallel_char,
  input logic [1:0] rx_parallel_valid,
  input logic [1:0] link_fault_indicator_n,
  input logic [19:0] reclock_char,
  input logic [1:0] reclock_char_valid,
  input logic [1:0] reclock_driver_one_enable,
  input logic [1:0] reclock_driver_two_enable,
  input logic [1:0] reclock_logic_power,
  input logic [1:0] rx_channel_power_latch,
  input logic [1:0] tx_driver_one_enable,
  input logic [1:0] tx_driver_two_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Properties
  // ****************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr_a;
    !config_write_strobe_n && cfg_addr == 4'h0;
  endsequence
  property p_rst_drv;
    !$past(rst_n) |-> (reclock_driver_one_enable | reclock_driver_two_enable | tx_driver_one_enable |
      tx_driver_two_enable) == 2'h0;
  endproperty
  a_rst_drv: assert property (p_rst_drv) else $error("driver enabled after reset");
  property p_rpwr;
    $stable(reclock_driver_one_enable[0] | reclock_driver_two_enable[0]) |->
      reclock_logic_power[0] == (reclock_driver_one_enable[0] | reclock_driver_two_enable[0]);
  endproperty
  a_rpwr: assert property (p_rpwr) else $error("reclock power mismatch");
  property p_rclk;
    reclock_char_valid[0] |-> $past(rx_char_valid[0]) && reclock_char[9:0] == $past(rx_char_in[9:0]);
  endproperty
  a_rclk: assert property (p_rclk) else $error("reclock char mismatch");
  property p_rclk_off;
    (!reclock_logic_power[0]) [*3] |-> !reclock_char_valid[0];
  endproperty
  a_rclk_off: assert property (p_rclk_off) else $error("reclock active while off");
  property p_par;
    rx_parallel_valid[0] |-> $past(rx_char_valid[0], 2) && rx_parallel_char[9:2] == $past(rx_char_in[9:2], 2);
  endproperty
  a_par: assert property (p_par) else $error("parallel char mismatch");
  property p_fault;
    (!rx_channel_power_latch[0]) [*2] |-> !link_fault_indicator_n[0];
  endproperty
  a_fault: assert property (p_fault) else $error("no fault while powered down");
  property p_off_in;
    (!rx_channel_power_latch[0]) [*4] |-> !rx_parallel_valid[0];
  endproperty
  a_off_in: assert property (p_off_in) else $error("char taken while powered down");
  property p_wr;
    s_wr_a |-> ##2 reclock_driver_one_enable[0] == $past(cfg_wdata[1], 2) &&
      reclock_driver_two_enable[0] == $past(cfg_wdata[2], 2);
  endproperty
  a_wr: assert property (p_wr) else $error("reclock enables not latched");
  property p_wrtx;
    s_wr_a |-> ##2 {tx_driver_two_enable[0], tx_driver_one_enable[0], rx_channel_power_latch[0]} ==
      {$past(cfg_wdata[4:3], 2), $past(cfg_wdata[0], 2)};
  endproperty
  a_wrtx: assert property (p_wrtx) else $error("tx or power latch not latched");
endmodule // rbcp_chk

// [rbcp_xmit.sv]
// Purpose: Remote transmitter sending the self-test pattern and a lock level
// Assumes: One character per clock while run is high
// Notes: Idle data toggles so a stale value never passes as a character
module rbcp_xmit (
  input logic clk,
  input logic rst_n,
  input logic run,
  input logic bad,
  input logic lock_req,
  output logic [9:0] char_q,
  output logic valid_q,
  output logic lock_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] lfsr_q;
  // ****************
  // Pattern source
  // ****************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_q <= 9'h1FF;
      char_q <= 10'h000;
      valid_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      lock_q <= lock_req;
      valid_q <= run;
      if (run) begin
        // Bad flips the top bit so every character miscompares
        char_q <= {lfsr_q, ^lfsr_q} ^ {bad, 9'h000};
        lfsr_q <= {lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]};
      end else begin
        char_q <= ~char_q;
        lfsr_q <= 9'h1FF;
      end
    end
  end
endmodule // rbcp_xmit

// [tb.sv]
// Purpose: Self-checking bench for the receive self-test and power block
// Assumes: One transmitter model feeds both channels
// Notes: Settling count shortened to 20 cycles
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 20;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] cfg_addr = 4'h0;
  logic [7:0] cfg_wdata = 8'h00;
  logic config_write_strobe_n = 1'b1;
  logic cfg_rd = 1'b0;
  logic run = 1'b0;
  logic bad = 1'b0;
  logic lock_req = 1'b1;
  logic chk_data = 1'b0;
  logic [9:0] m_char;
  logic m_valid, m_lock;
  logic [7:0] cfg_rdata, rd_val;
  logic [19:0] par_char, rcl_char;
  logic [1:0] par_valid, st_bit, lfi_n, rcl_valid, rdrv1, rdrv2, rpwr, settle, rxpwr, tdrv1, tdrv2, tpwr;
  logic [2:0] last_code;
  logic [9:0] sent[$];
  int err_count = 0;
  int checks = 0;
  int n_loop, n_err, n_wait, n_val, n_rcl;
  rbcp_top #(.SETTLE_CYCLES(SETTLE)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .config_write_strobe_n(config_write_strobe_n), .cfg_rd(cfg_rd),
    .cfg_rdata(cfg_rdata), .rx_char_in({m_char, m_char}), .rx_char_valid({2{m_valid}}),
    .rx_pll_lock({2{m_lock}}), .rx_parallel_char(par_char), .rx_parallel_valid(par_valid),
    .selftest_status_bit(st_bit), .link_fault_indicator_n(lfi_n), .reclock_char(rcl_char),
    .reclock_char_valid(rcl_valid), .reclock_driver_one_enable(rdrv1), .reclock_driver_two_enable(rdrv2),
    .reclock_logic_power(rpwr), .reclock_settling(settle), .rx_channel_power_latch(rxpwr),
    .tx_driver_one_enable(tdrv1), .tx_driver_two_enable(tdrv2), .tx_logic_power(tpwr));
  rbcp_xmit i_xmit (.clk(ref_clk), .rst_n(rst_n), .run(run), .bad(bad), .lock_req(lock_req),
    .char_q(m_char), .valid_q(m_valid), .lock_q(m_lock));
  initial forever #25 ref_clk = ~ref_clk;
  // ****************
  // Helpers
  // ****************
  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    config_write_strobe_n <= 1'b0;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge ref_clk);
    config_write_strobe_n <= 1'b1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge ref_clk);
    cfg_rd <= 1'b0;
    #1 rd_val = cfg_rdata;
  endtask
  task automatic snd(input int n, input logic b);
    run <= 1'b1;
    bad <= b;
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic stop;
    run <= 1'b0;
    bad <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic clr;
    {n_loop, n_err, n_wait, n_val, n_rcl} = '0;
  endtask
  task automatic rearm;
    wr(4'h0, 8'h01);
    wr(4'h0, 8'h41);
    repeat (2) @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    if (m_valid && chk_data) sent.push_back(m_char);
    if (rcl_valid[0]) n_rcl++;
    if (par_valid[0]) begin
      n_val++;
      last_code = {st_bit[0], par_char[0], par_char[1]};
      if (last_code == 3'h4) n_loop++;
      if (last_code == 3'h1) n_err++;
      if (last_code == 3'h6) n_wait++;
      if (chk_data) begin
        chk("parallel char", par_char[9:0], sent.pop_front());
        chk("status bit", st_bit[0], 1'b0);
      end
    end
  end
  // ****************
  // Scenarios
  // ****************
  task automatic t_power;
    chk("drivers", {rdrv1, rdrv2, tdrv1, tdrv2}, 8'h00);
    wr(4'h5, 8'hFF);
    rd(4'h5);
    chk("unmapped", rd_val, 8'h00);
    wr(4'h0, 8'h9E);
    wr(4'h1, 8'h18);
    repeat (3) @(posedge ref_clk);
    chk("reclock enables", {rdrv2, rdrv1}, 4'h5);
    chk("tx enables", {tdrv2, tdrv1, tpwr}, 6'h3F);
    rd(4'h0);
    chk("bank A", rd_val, 8'h1E);
    @(posedge ref_clk);
    clr;
    snd(4, 1'b0);
    stop;
    chk("chars while off", n_val, 0);
    chk("fault", lfi_n, 2'b00);
    wr(4'h0, 8'h01);
    chk_data = 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("reclock power", rpwr[0], 1'b0);
    snd(4, 1'b0);
    stop;
    chk("chars", n_val, 4);
    chk("reclock chars", n_rcl, 0);
    wr(4'h0, 8'h05);
    repeat (3) @(posedge ref_clk);
    chk("settling", settle[0], 1'b1);
    repeat (SETTLE + 3) @(posedge ref_clk);
    chk("settled", {settle[0], rpwr[0]}, 2'b01);
    snd(3, 1'b0);
    stop;
    chk("reclock chars", n_rcl, 3);
    chk_data = 1'b0;
    $display("test power done");
  endtask
  task automatic t_bist;
    rearm;
    chk("no fault", lfi_n, 2'b01);
    chk("power latch", rxpwr, 2'b01);
    clr;
    snd(1030, 1'b0);
    stop;
    chk("loops", n_loop, 2);
    chk("errors", n_err, 0);
    chk("chars", n_val, 1030);
    rd(4'h2);
    chk("state", rd_val[4:3], 2'h2);
    $display("test bist done");
  endtask
  task automatic t_abort;
    rearm;
    snd(6, 1'b0);
    clr;
    snd(20, 1'b1);
    stop;
    chk("error codes", n_err, 17);
    chk("wait codes", n_wait, 3);
    rd(4'h2);
    chk("state", rd_val[4:3], 2'h1);
    $display("test abort done");
  endtask
  task automatic t_lock;
    rearm;
    snd(6, 1'b0);
    lock_req <= 1'b0;
    snd(8, 1'b0);
    lock_req <= 1'b1;
    stop;
    chk("code after lock loss", last_code, 3'h6);
    rd(4'h2);
    chk("state", rd_val[4:3], 2'h1);
    $display("test lock done");
  endtask
  task automatic t_reset;
    wr(4'h0, 8'h7F);
    wr(4'h1, 8'h7F);
    repeat (2) @(posedge ref_clk);
    chk("status bit off", st_bit, 2'b00);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("drivers in reset", {rdrv1, rdrv2, tdrv1, tdrv2}, 8'h00);
    rst_n <= 1'b1;
    rd(4'h0);
    chk("bank A", rd_val, 8'h00);
    rd(4'h1);
    chk("bank B", rd_val, 8'h00);
    $display("test reset done");
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_power;
    t_bist;
    t_abort;
    t_lock;
    t_reset;
    finish_test;
  end
  initial begin
    repeat (4000) @(posedge ref_clk);
    err_count++;
    finish_test;
  end
endmodule // tb
bind rbcp_top rbcp_chk i_chk (.ref_clk(ref_clk), .rst_n(rst_n), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
  .config_write_strobe_n(config_write_strobe_n), .rx_char_in(rx_char_in), .rx_char_valid(rx_char_valid),
  .rx_parallel_char(rx_parallel_char), .rx_parallel_valid(rx_parallel_valid),
  .link_fault_indicator_n(link_fault_indicator_n), .reclock_char(reclock_char),
  .reclock_char_valid(reclock_char_valid), .reclock_driver_one_enable(reclock_driver_one_enable),
  .reclock_driver_two_enable(reclock_driver_two_enable), .reclock_logic_power(reclock_logic_power),
  .rx_channel_power_latch(rx_channel_power_latch), .tx_driver_one_enable(tx_driver_one_enable),
  .tx_driver_two_enable(tx_driver_two_enable));
